// >>> hdl/tcp_consts.svh
// Overview of operation
// - Mode 010b advances count once per selected pin edge, not per tick.
// - Polarity bit picks rising or falling pin edges; never both.
// - Counter mode ignores prescaler fields entirely.
// - Counter mode: cycle after count equals compare sets flag, count reloads to one.
// - Software count load affects first period only; later periods start at one.
// - Count is zero after reset.
// - Mode 011b toggles output after the tick where count equals match value.
// - PWM: tick after count equals compare reloads one, restores output, sets flag.
// - PWM polarity 0: output starts low, high at match, low at compare.
// - PWM polarity 1: output starts high, low at match, high at compare.
// - PWM period from count one equals compare value in prescaled ticks.
// - PWM and capture modes advance once per prescaled tick.
// - Mode 100b: tick after selected edge copies count to match, reloads one.
// - Capture without edge reloads one at compare, no copy.
// - Capture and compare end both set flag; interrupt raised when enabled.
// - A write to the flag field clears the flag, unless a flag set lands in the same cycle, which wins.
// - Count value is readable at all times.
// - Prescaler divides mclk by 1 to 4096.
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

`define TCP_MODE_COUNTER 3'h2
`define TCP_MODE_PWM     3'h3
`define TCP_MODE_CAPTURE 3'h4

`define TCP_COUNT_RESET  32'h0000_0000
`define TCP_COUNT_RELOAD 32'h0000_0001
`define TCP_COUNT_STEP   32'h0000_0001

`define TCP_PRESC_WIDTH   12
`define TCP_PRESC_MAX_EXP 4'hc
`define TCP_PRESC_ZERO    12'h000
`define TCP_PRESC_STEP    12'h001

`endif

// >>> hdl/tcp_pkg.sv
`default_nettype none
`include "tcp_consts.svh"

package tcp_pkg;

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic        pend;
    logic [31:0] count;
    logic [31:0] match;
    logic        flag;
    logic        irq;
    logic        pwm;
    logic        oe_n;
  } tcp_state_t;

  typedef struct packed {
    logic [`TCP_PRESC_WIDTH-1:0] cnt;
    logic                        tick;
  } tcp_presc_t;

endpackage

`default_nettype wire

// >>> hdl/tcp_prescaler.sv
`default_nettype none
`include "tcp_consts.svh"

module tcp_prescaler (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] exponent,
  output logic            tick
);

  tcp_pkg::tcp_presc_t          q;
  tcp_pkg::tcp_presc_t          d;
  logic [3:0]                   exp_c;
  logic [`TCP_PRESC_WIDTH-1:0]  mask;

  assign exp_c = (exponent > `TCP_PRESC_MAX_EXP) ? `TCP_PRESC_MAX_EXP : exponent;

  ////////////////////////////////////////////////////////////////////////
  // Divide by two to the exponent, 1 to 4096
  genvar i;
  generate
    for (i = 0; i < `TCP_PRESC_WIDTH; i++)
    begin : g_mask
      assign mask[i] = (4'(i) < exp_c);
    end
  endgenerate

  always_comb
  begin
    d = q;
    if (run)
    begin
      d.cnt  = q.cnt + `TCP_PRESC_STEP;
      d.tick = ((q.cnt & mask) == mask);
      if ((q.cnt & mask) == mask)
      begin
        d.cnt = `TCP_PRESC_ZERO;
      end
    end
    else
    begin
      d.cnt  = `TCP_PRESC_ZERO;
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

`default_nettype wire

// >>> hdl/tcp_timer.sv
`default_nettype none
`include "tcp_consts.svh"

module tcp_timer (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        timer_enable_bit,
  input  wire logic [2:0]  mode_select_field,
  input  wire logic        polarity_bit,
  input  wire logic [2:0]  prescale_low_field,
  input  wire logic        prescale_high_bit,
  input  wire logic [31:0] compare_value,
  input  wire logic        count_wr_en,
  input  wire logic [31:0] count_wr_data,
  input  wire logic        match_wr_en,
  input  wire logic [31:0] match_wr_data,
  input  wire logic        flag_clear,
  input  wire logic        irq_enable,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic [31:0]      count_value,
  output logic [31:0]      match_capture_value,
  output logic             period_event_flag,
  output logic             timer_irq
);

  localparam tcp_pkg::tcp_state_t RST_STATE = '{
    sync1: 1'b0,
    sync2: 1'b0,
    prev:  1'b0,
    pend:  1'b0,
    count: `TCP_COUNT_RESET,
    match: `TCP_COUNT_RESET,
    flag:  1'b0,
    irq:   1'b0,
    pwm:   1'b0,
    oe_n:  1'b1
  };

  tcp_pkg::tcp_state_t q;
  tcp_pkg::tcp_state_t d;
  logic                cnt_mode;
  logic                pwm_mode;
  logic                cap_mode;
  logic                edge_sel;
  logic                hit_cmp;
  logic                hit_match;
  logic                tick;
  logic                pend_any;
  logic                set_flag;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode and comparisons
  assign cnt_mode  = timer_enable_bit && (mode_select_field == `TCP_MODE_COUNTER);
  assign pwm_mode  = timer_enable_bit && (mode_select_field == `TCP_MODE_PWM);
  assign cap_mode  = timer_enable_bit && (mode_select_field == `TCP_MODE_CAPTURE);
  assign hit_cmp   = (q.count == compare_value);
  assign hit_match = (q.count == q.match);

  assign edge_sel = (q.sync2 != q.prev) && (q.sync2 == ~polarity_bit);
  assign pend_any = q.pend || edge_sel;

  assign set_flag = (cnt_mode && hit_cmp)
                  || (pwm_mode && tick && hit_cmp)
                  || (cap_mode && tick && (pend_any || hit_cmp));

  ////////////////////////////////////////////////////////////////////////
  // Prescaled tick, idle in counter mode
  // prescaler not used for counting edges
  tcp_prescaler u_presc (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .run      (pwm_mode || cap_mode),
    .exponent ({prescale_high_bit, prescale_low_field}),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d       = q;
    d.sync1 = pin_in;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    d.pend  = 1'b0;
    if (cnt_mode)
    begin
      if (hit_cmp)
      begin
        d.count = `TCP_COUNT_RELOAD;
      end
      else if (edge_sel)
      begin
        d.count = q.count + `TCP_COUNT_STEP;
      end
    end
    else if (pwm_mode)
    begin
      if (tick)
      begin
        if (hit_cmp)
        begin
          d.count = `TCP_COUNT_RELOAD;
          d.pwm   = polarity_bit;
        end
        else
        begin
          d.count = q.count + `TCP_COUNT_STEP;
          if (hit_match)
          begin
            d.pwm = ~polarity_bit;
          end
        end
      end
    end
    else if (cap_mode)
    begin
      d.pend = tick ? 1'b0 : pend_any;
      if (tick)
      begin
        if (pend_any)
        begin
          d.match = q.count;
          d.count = `TCP_COUNT_RELOAD;
        end
        else if (hit_cmp)
        begin
          d.count = `TCP_COUNT_RELOAD;
        end
        else
        begin
          d.count = q.count + `TCP_COUNT_STEP;
        end
      end
    end
    if (!pwm_mode)
    begin
      d.pwm = polarity_bit;
    end
    d.oe_n = (mode_select_field != `TCP_MODE_PWM);
    // software load only seeds one period
    if (count_wr_en)
    begin
      d.count = count_wr_data;
    end
    if (match_wr_en)
    begin
      d.match = match_wr_data;
    end
    d.flag = set_flag || (q.flag && !flag_clear);
    d.irq  = d.flag && irq_enable;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q <= RST_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  assign count_value         = q.count;
  assign match_capture_value = q.match;
  assign period_event_flag   = q.flag;
  assign timer_irq           = q.irq;
  assign pin_out             = q.pwm;
  assign pin_oe_n            = q.oe_n;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_pwm_end;
    pwm_mode && tick && hit_cmp && !count_wr_en;
  endsequence

  sequence s_pwm_match;
    pwm_mode && tick && !hit_cmp && hit_match && !count_wr_en;
  endsequence

  sequence s_cap_event;
    cap_mode && tick && pend_any && !count_wr_en && !match_wr_en;
  endsequence

  sequence s_cap_step;
    cap_mode && tick && !pend_any && !hit_cmp && !count_wr_en;
  endsequence

  a_cnt_reload: assert property (
    cnt_mode && hit_cmp && !count_wr_en
    |=> (count_value == `TCP_COUNT_RELOAD) && period_event_flag)
    else $error("counter mode missed reload at compare");

  a_cnt_edge: assert property (
    cnt_mode && !hit_cmp && edge_sel && !count_wr_en
    |=> count_value == $past(count_value) + `TCP_COUNT_STEP)
    else $error("counter mode missed a pin edge");

  a_cnt_noedge: assert property (
    cnt_mode && !hit_cmp && !edge_sel && !count_wr_en
    |=> $stable(count_value))
    else $error("counter mode counted without an edge");

  a_edge_pol: assert property (
    edge_sel |-> ($past(pin_in, 2) != polarity_bit) && (q.prev == polarity_bit))
    else $error("edge of wrong polarity accepted");

  a_pwm_toggle: assert property (
    s_pwm_match |=> pin_out == ~polarity_bit)
    else $error("pwm output did not toggle at match");

  a_pwm_end: assert property (
    s_pwm_end |=> (count_value == `TCP_COUNT_RELOAD)
      && (pin_out == $past(polarity_bit)) && period_event_flag)
    else $error("pwm period end wrong");

  a_pwm_idle: assert property (
    timer_enable_bit && pwm_mode && !tick && !count_wr_en
    |=> $stable(count_value))
    else $error("pwm count moved without a tick");

  a_cap_copy: assert property (
    s_cap_event |=> (match_capture_value == $past(count_value))
      && (count_value == `TCP_COUNT_RELOAD) && period_event_flag)
    else $error("capture event not handled");

  a_cap_nocap: assert property (
    cap_mode && tick && !pend_any && hit_cmp && !count_wr_en && !match_wr_en
    |=> (count_value == `TCP_COUNT_RELOAD) && $stable(match_capture_value))
    else $error("capture compare end wrong");

  a_flag_clear: assert property (
    flag_clear && !set_flag |=> !period_event_flag)
    else $error("flag not cleared");

  a_flag_irq: assert property (
    irq_enable ##1 period_event_flag |-> timer_irq)
    else $error("interrupt not raised for flag");

  a_irq_gate: assert property (
    !irq_enable |=> !timer_irq)
    else $error("interrupt raised while masked");

  a_flag_set: assert property (
    set_flag |=> period_event_flag)
    else $error("flag clear beat a period end");

  a_count_load: assert property (
    count_wr_en |=> count_value == $past(count_wr_data))
    else $error("software count load lost");

  a_presc_idle: assert property (
    cnt_mode && $past(cnt_mode) |-> !tick)
    else $error("prescaler ran in counter mode");

  a_pwm_level: assert property (
    !pwm_mode |=> pin_out == $past(polarity_bit))
    else $error("idle output not at polarity level");

  a_pwm_hold: assert property (
    pwm_mode && !(tick && (hit_cmp || hit_match)) |=> $stable(pin_out))
    else $error("pwm output moved between transitions");

  a_pwm_drive: assert property (
    1'b1 |=> pin_oe_n == ($past(mode_select_field) != `TCP_MODE_PWM))
    else $error("pin drive does not follow pwm mode");

  a_cap_pend: assert property (
    cap_mode && !tick && edge_sel |=> q.pend)
    else $error("capture edge not held for the tick");

  a_cap_step: assert property (
    s_cap_step |=> count_value == $past(count_value) + `TCP_COUNT_STEP)
    else $error("capture count did not advance on tick");

  a_reset_count: assert property (disable iff (1'b0)
    !rst_n |=> count_value == `TCP_COUNT_RESET)
    else $error("count not zero after reset");

endmodule

`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
`include "tcp_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        timer_enable_bit, polarity_bit, prescale_high_bit, irq_enable;
  logic        count_wr_en, match_wr_en, flag_clear;
  logic [2:0]  mode_select_field, prescale_low_field;
  logic [31:0] compare_value, count_wr_data, match_wr_data;
  wire         pin_in;
  logic        pin_out, pin_oe_n, period_event_flag, timer_irq;
  logic [31:0] count_value, match_capture_value;
  int          err_total = 0;
  int          tests_run = 0;

  tcp_timer DUT (.mclk, .rst_n, .timer_enable_bit, .mode_select_field, .polarity_bit,
    .prescale_low_field, .prescale_high_bit, .compare_value, .count_wr_en, .count_wr_data,
    .match_wr_en, .match_wr_data, .flag_clear, .irq_enable, .pin_in, .pin_out, .pin_oe_n,
    .count_value, .match_capture_value, .period_event_flag, .timer_irq);

  tcp_pin_model m_pin (.mclk, .pin_out, .pin_oe_n, .pin_in);

  always #4 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic lost();
    err_total++;
    $display("[FAIL] %0t wait ran out", $time);
    test_done();
  endtask

  task automatic clr();
    @(negedge mclk);
    flag_clear = 1'b1;
    @(negedge mclk);
    flag_clear = 1'b0;
  endtask

  task automatic wait_flag();
    int n = 0;
    while (period_event_flag !== 1'b1 && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 3000)
      lost();
  endtask

  task automatic span(input logic lvl, output int n);
    n = 0;
    while (pin_out === lvl && n < 5000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 5000)
      lost();
  endtask

  task automatic setup(input logic [2:0] md, input logic p, input logic [3:0] e,
                       input logic [31:0] cmp, input logic [31:0] cnt, input logic [31:0] mt);
    @(negedge mclk);
    timer_enable_bit = 1'b0;
    mode_select_field = md;
    polarity_bit = p;
    {prescale_high_bit, prescale_low_field} = e;
    compare_value = cmp;
    count_wr_en = 1'b1;
    count_wr_data = cnt;
    match_wr_en = 1'b1;
    match_wr_data = mt;
    @(negedge mclk);
    count_wr_en = 1'b0;
    match_wr_en = 1'b0;
    flag_clear = 1'b1;
    @(negedge mclk);
    flag_clear = 1'b0;
    timer_enable_bit = 1'b1;
  endtask

  task automatic pwm(input logic p, input logic [3:0] e, input logic [31:0] mt,
                     input logic [31:0] cmp);
    int n;
    int h;
    setup(`TCP_MODE_PWM, p, e, cmp, 32'h0000_0001, mt);
    check(32'(pin_out), 32'(p));
    span(p, n);
    span(~p, h);
    check(32'(h), (cmp - mt) << e);
    check(count_value, 32'h0000_0001);
    check(32'({period_event_flag, pin_oe_n}), 32'h0000_0002);
    span(p, n);
    check(32'(n), mt << e);
    check(32'(h + n), cmp << e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {timer_enable_bit, polarity_bit, prescale_high_bit, count_wr_en} = 4'h0;
    {match_wr_en, flag_clear} = 2'h0;
    irq_enable = 1'b1;
    mode_select_field = 3'h0;
    prescale_low_field = 3'h0;
    compare_value = 32'h0000_0000;
    count_wr_data = 32'h0000_0000;
    match_wr_data = 32'h0000_0000;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    check(count_value, 32'h0000_0000);
    check(32'({period_event_flag, pin_oe_n}), 32'h0000_0001);
    // Pin edge counting, both polarities
    for (int p = 0; p < 2; p++)
    begin
      m_pin.level(p[0], 4);
      setup(`TCP_MODE_COUNTER, p[0], 4'h5, 32'h0000_0003, 32'h0000_0000, 32'h0000_0000);
      for (int i = 1; i < 5; i++)
      begin
        m_pin.level(~p[0], 4);
        check(count_value, 32'((i < 3) ? i : i - 2));
        m_pin.level(p[0], 4);
        check(count_value, 32'((i < 3) ? i : i - 2));
        if (i == 3)
          check(32'({period_event_flag, timer_irq}), 32'h0000_0003);
      end
    end
    clr();
    check(32'(period_event_flag), 32'h0000_0000);
    pwm(1'b0, 4'h0, 32'h0000_0002, 32'h0000_0004);
    pwm(1'b1, 4'h1, 32'h0000_0003, 32'h0000_0005);
    // Capture of edge spacing, then compare end
    m_pin.level(1'b0, 4);
    setup(`TCP_MODE_CAPTURE, 1'b0, 4'h0, 32'h0000_0400, 32'h0000_0001, 32'h0000_0000);
    m_pin.level(1'b1, 4);
    check(match_capture_value, 32'h0000_0003);
    m_pin.level(1'b0, 4);
    clr();
    m_pin.level(1'b1, 4);
    wait_flag();
    check(match_capture_value, 32'h0000_000c);
    irq_enable = 1'b0;
    clr();
    wait_flag();
    check(count_value, 32'h0000_0001);
    check(match_capture_value, 32'h0000_000c);
    check(32'({period_event_flag, timer_irq}), 32'h0000_0002);
    test_done();
  end
endmodule

`default_nettype wire

// >>> testbench/tcp_pin_model.sv
`default_nettype none

module tcp_pin_model (
  input  wire logic mclk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic src_q = 1'b0;

  // Device level wins while it drives
  assign pin_in = pin_oe_n ? src_q : pin_out;

  task automatic level(input logic v, input int n);
    @(negedge mclk);
    src_q = v;
    repeat (n) @(negedge mclk);
  endtask
endmodule

`default_nettype wire
